// ### flash_cmd_regs.vh
// Register map, field positions and codes of the flash command and status interface
// Notes on behaviour
// R1 - No-argument commands take a zero argument
// R2 - Plane erase argument is a page inside plane
// R3 - Sector erase argument is a page inside sector
// R4 - Multi-page erase low bits pick 4/8/16/32 pages
// R5 - Multi-page erase start page in argument bits 15:2
// R6 - Larger multi-page erases align start, zero low bits; the code clears only argument bits 1:0, for every page count
// R7 - Programming commands carry the target page number
// R8 - Lock commands carry page of lock region
// R9 - General bit commands select the bit number
// R10 - Act on command only with correct key
// R11 - Ready flag high when idle, low when busy
// R12 - Interrupt while ready and interrupt enable set
// R13 - Ready rises again only on operation completion
// R14 - Command error set on bad code/key, cleared
// R15 - Locked region error set on attempt, cleared
// R16 - Verify error set on fail, cleared on program/erase start
// R17 - Single ECC low half, sticky until read
// R18 - Multi ECC low half, sticky until read
// R19 - Single ECC high half, sticky until read
// R20 - Multi ECC high half, sticky until read
// R21 - Result register steps through multi-word results
// R22 - Ready interrupt enable gates the interrupt
// R23 - Accepted command clears ready in write cycle
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

`define OFS_MODE 8'h00
`define OFS_COMMAND 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT 8'h0C

`define MODE_RESET 32'h0400_0000
`define MODE_WMASK 32'h0501_0F01
`define MODE_READY_IEN 0
`define MODE_WS_LO 8
`define MODE_WS_HI 11
`define MODE_SEQ_DIS 16
`define MODE_ACC64 24
`define MODE_LOOP_EN 26

`define CMD_CODE_HI 7
`define CMD_ARG_LO 8
`define CMD_ARG_HI 23
`define CMD_KEY_LO 24
`define KEY_VALUE 8'h5A

`define ST_READY 0
`define ST_CMD_ERR 1
`define ST_LOCK_ERR 2
`define ST_VERIFY_ERR 3
`define ST_SINGLE_ECC_LO 16
`define ST_MULTI_ECC_LO 17
`define ST_SINGLE_ECC_HI 18
`define ST_MULTI_ECC_HI 19

`define CODE_WRITE_PAGE 8'h01
`define CODE_ERASE_PLANE 8'h06
`define CODE_ERASE_MULTI_PAGE 8'h07
`define CODE_ERASE_SECTOR 8'h11
`define CODE_WRITE_SIGNATURE 8'h12
`define CODE_ERASE_SIGNATURE 8'h13
`define CODE_LAST 8'h15

`endif

// ### result_store.v
// Word store for multi-word command results, read back in order
`timescale 1ns/100ps
`default_nettype none
module result_store #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Control
    input wire clear,
    input wire push,
    input wire [WIDTH-1:0] push_data,
    input wire pop,
    // Current word
    output wire [WIDTH-1:0] word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_r;
    reg [AW:0] rd_r;

    // Past the last word the register reads as zero
    assign word = (rd_r < wr_r) ? mem[rd_r[AW-1:0]] : {WIDTH{1'b0}};

    always @(posedge clk) begin
        if (push && !clear && wr_r < DEPTH) begin
            mem[wr_r[AW-1:0]] <= push_data;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else if (clear) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else begin
            if (push && wr_r < DEPTH) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop && rd_r < wr_r) begin
                rd_r <= rd_r + 1'b1; // R21
            end
        end
    end
endmodule
`default_nettype wire

// ### flash_cmd_status_interface.v
// Command, status and result registers of the embedded flash controller
`include "flash_cmd_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_status_interface #(
    parameter RESULT_DEPTH = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Avalon-MM slave
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Interrupt
    output reg ready_irq,
    // Flash array operation request
    output reg op_start,
    output reg [7:0] op_code,
    output reg [15:0] op_arg,
    output reg [15:0] op_page,
    output reg [5:0] op_page_count,
    // Flash array completion and results
    input wire op_done,
    input wire op_verify_fail,
    input wire op_lock_hit,
    input wire result_valid,
    input wire [31:0] result_value,
    // ECC events from read accesses
    input wire single_ecc_low_half,
    input wire multi_ecc_low_half,
    input wire single_ecc_high_half,
    input wire multi_ecc_high_half,
    // Mode fields towards the read path
    output wire [3:0] wait_states,
    output wire seq_opt_disable,
    output wire access_64bit,
    output wire loop_opt_enable
);
    reg [31:0] mode_r;
    reg ready_flag_r;
    reg command_error_flag_r;
    reg locked_region_error_flag_r;
    reg verify_error_flag_r;
    reg [3:0] ecc_r;
    reg [31:0] snap_r;

    reg ready_flag_nxt;
    reg command_error_flag_nxt;
    reg locked_region_error_flag_nxt;
    reg verify_error_flag_nxt;
    reg [3:0] ecc_nxt;
    reg [31:0] mode_nxt;

    wire [31:0] result_word;
    wire result_push;
    wire busy;
    wire [3:0] ecc_events;
    wire accept;
    wire wr_mode;
    wire wr_cmd;
    wire rd_status;
    wire rd_result;
    wire [7:0] command_code;
    wire [15:0] command_argument;
    wire [7:0] write_protect_key;
    wire key_ok;
    wire code_ok;
    wire cmd_go;
    wire [31:0] status_word;
    wire [15:0] launch_page;
    wire [5:0] launch_count;

    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0] be;
        integer i;
        begin
            merge_bytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Store pointer width follows the depth, so a deeper store stays consistent
    function integer addr_bits;
        input integer depth;
        integer n;
        begin
            addr_bits = 1;
            for (n = 2; n < depth; n = n * 2) begin
                addr_bits = addr_bits + 1;
            end
        end
    endfunction

    localparam RESULT_AW = addr_bits(RESULT_DEPTH);

    // Commands that program or erase the array
    function is_program_erase;
        input [7:0] code;
        begin
            is_program_erase = (code >= `CODE_WRITE_PAGE && code <= `CODE_ERASE_MULTI_PAGE)
                || code == `CODE_ERASE_SECTOR || code == `CODE_WRITE_SIGNATURE
                || code == `CODE_ERASE_SIGNATURE;
        end
    endfunction

    function [5:0] page_count;
        input [1:0] sel;
        begin
            case (sel)
                2'd0: page_count = 6'd4;
                2'd1: page_count = 6'd8;
                2'd2: page_count = 6'd16;
                default: page_count = 6'd32;
            endcase
        end
    endfunction

    // Read mux; the command register is write-only and reads as zero
    function [31:0] read_word;
        input [7:0] addr;
        input [31:0] mode;
        input [31:0] status;
        input [31:0] result;
        begin
            case (addr)
                `OFS_MODE: read_word = mode;
                `OFS_STATUS: read_word = status; // R11
                `OFS_RESULT: read_word = result; // R21
                default: read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // Requests take effect at the edge where waitrequest is seen low
    assign accept = (read || write) && !waitrequest;
    assign wr_mode = accept && write && address == `OFS_MODE;
    assign wr_cmd = accept && write && address == `OFS_COMMAND;
    assign rd_status = accept && read && address == `OFS_STATUS;
    assign rd_result = accept && read && address == `OFS_RESULT;

    assign command_code = writedata[`CMD_CODE_HI:0];
    assign command_argument = writedata[`CMD_ARG_HI:`CMD_ARG_LO];
    assign write_protect_key = writedata[31:`CMD_KEY_LO];
    // Partial writes count as bad keys, even when lane 3 carries the whole key
    assign key_ok = write_protect_key == `KEY_VALUE && byteenable == 4'hF; // R10
    assign code_ok = command_code <= `CODE_LAST;
    // A command written while busy is dropped and flagged
    assign cmd_go = wr_cmd && key_ok && code_ok && ready_flag_r; // R10

    // Event pulses from the read path, accepted in any cycle
    assign ecc_events = {multi_ecc_high_half, single_ecc_high_half,
                         multi_ecc_low_half, single_ecc_low_half};

    // Array events count only while an operation runs
    assign busy = !ready_flag_r;
    assign result_push = result_valid && busy;

    // Reserved status bits read as zero
    assign status_word = {12'h000, ecc_r, 12'h000, verify_error_flag_r,
                          locked_region_error_flag_r, command_error_flag_r, ready_flag_r};

    assign wait_states = mode_r[`MODE_WS_HI:`MODE_WS_LO];
    assign seq_opt_disable = mode_r[`MODE_SEQ_DIS];
    assign access_64bit = mode_r[`MODE_ACC64];
    assign loop_opt_enable = mode_r[`MODE_LOOP_EN];

    // Multi-page erase starts on a four-page boundary; other commands touch one page
    assign launch_page = (command_code == `CODE_ERASE_MULTI_PAGE)
        ? {command_argument[15:2], 2'b00} : command_argument; // R5
    assign launch_count = (command_code == `CODE_ERASE_MULTI_PAGE)
        ? page_count(command_argument[1:0]) : 6'd1; // R4

    // A launch empties the store before the new results arrive
    result_store #(
        .WIDTH(32),
        .DEPTH(RESULT_DEPTH),
        .AW(RESULT_AW)
    ) u_result (
        .clk(clk),
        .rst_b(rst_b),
        .clear(cmd_go),
        .push(result_push),
        .push_data(result_value),
        .pop(rd_result),
        .word(result_word)
    );

    always @* begin
        mode_nxt = mode_r;
        if (wr_mode) begin
            // Only the defined mode bits are stored, each per byte lane
            mode_nxt = (merge_bytes(mode_r, writedata, byteenable) & `MODE_WMASK)
                | (mode_r & ~`MODE_WMASK);
        end

        ready_flag_nxt = ready_flag_r;
        if (cmd_go) begin
            ready_flag_nxt = 1'b0; // R23 R11
        end else if (op_done && busy) begin
            ready_flag_nxt = 1'b1; // R13 R11
        end

        // Clears first, sets after, so a coincident event survives
        command_error_flag_nxt = command_error_flag_r;
        locked_region_error_flag_nxt = locked_region_error_flag_r;
        if (wr_cmd || (rd_status && snap_r[`ST_CMD_ERR])) begin
            command_error_flag_nxt = 1'b0; // R14
        end
        if (wr_cmd || (rd_status && snap_r[`ST_LOCK_ERR])) begin
            locked_region_error_flag_nxt = 1'b0; // R15
        end
        if (wr_cmd && !cmd_go) begin
            command_error_flag_nxt = 1'b1; // R14
        end
        if (op_lock_hit && busy) begin
            locked_region_error_flag_nxt = 1'b1; // R15
        end

        verify_error_flag_nxt = verify_error_flag_r;
        if (cmd_go && is_program_erase(command_code)) begin
            verify_error_flag_nxt = 1'b0; // R16
        end
        if (op_done && op_verify_fail && busy) begin
            verify_error_flag_nxt = 1'b1; // R16
        end

        // Only bits that were reported are cleared by the read
        ecc_nxt = ecc_r;
        if (rd_status) begin
            ecc_nxt = ecc_r & ~snap_r[`ST_MULTI_ECC_HI:`ST_SINGLE_ECC_LO]; // R17 R18 R19 R20
        end
        ecc_nxt = ecc_nxt | ecc_events; // R17 R18 R19 R20
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `MODE_RESET;
            ready_flag_r <= 1'b1;
            command_error_flag_r <= 1'b0;
            locked_region_error_flag_r <= 1'b0;
            verify_error_flag_r <= 1'b0;
            ecc_r <= 4'h0;
            ready_irq <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            ready_flag_r <= ready_flag_nxt;
            command_error_flag_r <= command_error_flag_nxt;
            locked_region_error_flag_r <= locked_region_error_flag_nxt;
            verify_error_flag_r <= verify_error_flag_nxt;
            ecc_r <= ecc_nxt;
            // The enable follows a mode write at once, lane by lane
            ready_irq <= ready_flag_nxt && mode_nxt[`MODE_READY_IEN]; // R12 R22
        end
    end

    // Command launch towards the array
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_start <= 1'b0;
            op_code <= 8'h00;
            op_arg <= 16'h0000;
            op_page <= 16'h0000;
            op_page_count <= 6'd0;
        end else begin
            op_start <= cmd_go;
            if (cmd_go) begin
                op_code <= command_code;
                // Argument is passed through: page, plane, sector, lock page or bit number
                op_arg <= command_argument; // R2 R3 R7 R8 R9
                op_page <= launch_page; // R5
                op_page_count <= launch_count; // R4
            end
        end
    end

    // Bus slave: one wait cycle, data captured as waitrequest falls
    // Back-to-back requests cost two cycles each
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            snap_r <= 32'h0000_0000;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
            snap_r <= status_word;
            if (read) begin
                readdata <= read_word(address, mode_r, status_word, result_word); // R11 R21
            end
        end
    end
endmodule
`default_nettype wire

// ### flash_cmd_status_interface_dummy_guard.v
// Intentionally empty companion file holding no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### flash_cmd_status_interface_properties.sv
// Concurrent checks on the flash command, status and interrupt ports
`timescale 1ns/100ps
`default_nettype none
module cmd_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Interrupt and array side
    input wire logic ready_irq,
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_arg,
    input wire logic [15:0] op_page,
    input wire logic [5:0] op_page_count,
    input wire logic op_done
);
    logic busy_r;
    wire cmd_go = write && !waitrequest && address == 8'h04;
    wire st_rd = read && !waitrequest && address == 8'h08;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Busy from launch to completion, so status reads can be judged
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            busy_r <= 1'b0;
        else if (op_start)
            busy_r <= 1'b1;
        else if (op_done)
            busy_r <= 1'b0;
    end
    AST_BAD_KEY: assert property (cmd_go && writedata[31:24] != 8'h5A |=> !op_start)
        else $error("command launched with wrong key");
    AST_KEYED: assert property (op_start |-> $past(cmd_go && writedata[31:24] == 8'h5A))
        else $error("launch without keyed write");
    AST_HOLD: assert property (busy_r |-> !ready_irq)
        else $error("ready before completion");
    AST_IRQ_CAUSE: assert property ($rose(ready_irq) |-> $past(op_done) || $past(op_done, 2)
        || $past(write && address == 8'h00 && writedata[0]))
        else $error("interrupt without cause");
    AST_IRQ_OFF: assert property (write && !waitrequest && address == 8'h00 && !writedata[0]
        |=> !ready_irq)
        else $error("interrupt while disabled");
    AST_READY_LOW: assert property (st_rd && busy_r |-> !readdata[0])
        else $error("ready reads high while busy");
    AST_PAGES: assert property (op_start && op_code == 8'h07 |->
        op_page_count == (6'h04 << op_arg[1:0]) && op_page == {op_arg[15:2], 2'b00})
        else $error("wrong page count or start page");
    AST_FIELDS: assert property (op_start |->
        op_arg == $past(writedata[23:8]) && op_code == $past(writedata[7:0]))
        else $error("launched fields differ from write");
endmodule
`default_nettype wire

// ### flash_array_model.sv
// Behavioural flash array: slow completion, two result words, fault injection
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requests and scenario controls
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_page,
    input wire logic [7:0] dly,
    input wire logic [1:0] fault,
    // Completion and results
    output logic op_done,
    output logic op_verify_fail,
    output logic op_lock_hit,
    output logic result_valid,
    output logic [31:0] result_value
);
    logic [7:0] cnt;
    logic [31:0] word_r;
    logic tog_r;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            word_r <= 32'h0000_0000;
            tog_r <= 1'b0;
        end else begin
            tog_r <= !tog_r;
            if (op_start) begin
                cnt <= dly;
                word_r <= {8'h00, op_code, op_page};
            end else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
    assign op_done = cnt == 8'h01;
    assign op_verify_fail = op_done && fault[0];
    assign op_lock_hit = cnt == 8'h02 && fault[1];
    assign result_valid = cnt == 8'h03 || cnt == 8'h02;
    // Outside push cycles the word changes, so a stale sample shows
    assign result_value = cnt == 8'h03 ? word_r : cnt == 8'h02 ? ~word_r : word_r ^ {32{tog_r}};
endmodule
`default_nettype wire

// ### flash_cmd_status_interface_bench.sv
// Self-checking bench for the flash command, status and result registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module flash_cmd_status_interface_bench;
    localparam logic [21:0] NOARG = 22'h3D_E421;
    logic clk = 0, rst_b = 0, read = 0, write = 0;
    logic [7:0] address = 8'h00, op_code, dly = 8'h06;
    logic [31:0] writedata = 32'h0000_0000, readdata, q, result_value;
    logic waitrequest, ready_irq, op_start, op_done, op_verify_fail, op_lock_hit, result_valid;
    logic [15:0] op_arg, op_page;
    logic [5:0] op_page_count;
    logic [1:0] fault = 2'b00;
    logic [3:0] ecc = 4'h0;
    logic [3:0] be = 4'hF, wait_states;
    logic seq_opt_disable, access_64bit, loop_opt_enable;
    int error_cnt = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    flash_cmd_status_interface dut_u (.clk(clk), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(be),
        .readdata(readdata), .waitrequest(waitrequest), .ready_irq(ready_irq),
        .op_start(op_start), .op_code(op_code), .op_arg(op_arg), .op_page(op_page),
        .op_page_count(op_page_count), .op_done(op_done), .op_verify_fail(op_verify_fail),
        .op_lock_hit(op_lock_hit), .result_valid(result_valid), .result_value(result_value),
        .single_ecc_low_half(ecc[0]), .multi_ecc_low_half(ecc[1]),
        .single_ecc_high_half(ecc[2]), .multi_ecc_high_half(ecc[3]),
        .wait_states(wait_states), .seq_opt_disable(seq_opt_disable),
        .access_64bit(access_64bit), .loop_opt_enable(loop_opt_enable));
    flash_array_model array_u (.clk(clk), .rst_b(rst_b), .op_start(op_start),
        .op_code(op_code), .op_page(op_page), .dly(dly), .fault(fault), .op_done(op_done),
        .op_verify_fail(op_verify_fail), .op_lock_hit(op_lock_hit),
        .result_valid(result_valid), .result_value(result_value));
    task results(input int miss);
        error_cnt += miss;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
            results(1);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 32'h0000_0000, 1'b0);
        `CHK(q, e)
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] g);
        xfer(8'h04, {8'h5A, g, c}, 1'b1);
    endtask
    // Two edges first: the interrupt falls at the launch edge and reads low from the next edge
    task automatic wait_rdy;
        int n;
        repeat (2) @(posedge clk);
        for (n = 0; n < 300 && ready_irq !== 1'b1; n++)
            @(posedge clk);
        if (n >= 300)
            results(1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h08, 32'h0000_0001);
        rd(8'h00, 32'h0400_0000);
        for (int m = 1; m >= 0; m--) begin
            xfer(8'h00, {31'h0200_0000, m[0]}, 1'b1);
            @(posedge clk);
            `CHK(ready_irq, m[0])
        end
        xfer(8'h00, 32'hFFFF_FFFF, 1'b1);
        rd(8'h00, 32'h0501_0F01);
        `CHK({wait_states, seq_opt_disable, access_64bit, loop_opt_enable}, 7'h7F)
        // Lane 0 masked: the interrupt enable must survive
        be <= 4'h2;
        xfer(8'h00, 32'h0000_0001, 1'b1);
        be <= 4'hF;
        @(posedge clk);
        `CHK({ready_irq, wait_states}, 5'h10)
        xfer(8'h00, 32'h0400_0001, 1'b1);
        $display("mode test done");
        xfer(8'h04, 32'hA501_0040, 1'b1);
        rd(8'h08, 32'h0000_0003);
        rd(8'h08, 32'h0000_0001);
        be <= 4'h7;
        cmd(8'h0E, 16'h0000);
        be <= 4'hF;
        rd(8'h08, 32'h0000_0003);
        cmd(8'h16, 16'h0000);
        rd(8'h08, 32'h0000_0003);
        cmd(8'h0E, 16'h0000);
        wait_rdy();
        rd(8'h08, 32'h0000_0001);
        $display("error flag test done");
        for (int c = 0; c < 22; c++) begin
            cmd(c[7:0], NOARG[c] ? 16'h0000 : 16'h0040);
            wait_rdy();
            rd(8'h08, 32'h0000_0001);
        end
        for (int k = 0; k < 4; k++) begin
            cmd(8'h07, 16'h0100 | k[15:0]);
            wait_rdy();
            rd(8'h0C, 32'h0007_0100);
        end
        $display("command set test done");
        dly <= 8'h28;
        cmd(8'h01, 16'h0040);
        rd(8'h08, 32'h0000_0000);
        wait_rdy();
        rd(8'h0C, 32'h0001_0040);
        rd(8'h0C, 32'hFFFE_FFBF);
        rd(8'h0C, 32'h0000_0000);
        $display("busy and result test done");
        dly <= 8'h06;
        fault <= 2'b01;
        cmd(8'h01, 16'h0040);
        wait_rdy();
        rd(8'h08, 32'h0000_0009);
        fault <= 2'b10;
        cmd(8'h0A, 16'h0000);
        wait_rdy();
        rd(8'h08, 32'h0000_000D);
        rd(8'h08, 32'h0000_0009);
        fault <= 2'b00;
        cmd(8'h01, 16'h0040);
        wait_rdy();
        rd(8'h08, 32'h0000_0001);
        $display("fault test done");
        for (int b = 0; b < 4; b++) begin
            ecc <= 4'h1 << b;
            @(posedge clk);
            ecc <= 4'h0;
            rd(8'h08, 32'h0000_0001 | (32'h0001_0000 << b));
            rd(8'h08, 32'h0000_0001);
        end
        $display("ecc test done");
        dly <= 8'h28;
        cmd(8'h01, 16'h0040);
        repeat (4) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h08, 32'h0000_0001);
        rd(8'h00, 32'h0400_0000);
        rd(8'h0C, 32'h0000_0000);
        `CHK(ready_irq, 1'b0)
        $display("reset test done");
        results(0);
    end
endmodule
bind flash_cmd_status_interface cmd_checker chk_u (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ready_irq(ready_irq),
    .op_start(op_start), .op_code(op_code), .op_arg(op_arg), .op_page(op_page),
    .op_page_count(op_page_count), .op_done(op_done));
`default_nettype wire
